// >>> hw/rrse_defs.vh
`ifndef RRSE_DEFS_VH
`define RRSE_DEFS_VH
// opcode patterns (14-bit instruction word)
`define RRSE_LIT_EXIT_HI   4'hD
`define RRSE_SUB_EXIT_OP   14'h0008
`define RRSE_ROT_RIGHT_HI  6'h0C
`define RRSE_ROT_LEFT_HI   6'h0D
`define RRSE_POWERDOWN_OP  14'h0063
// field positions
`define RRSE_DEST_BIT      7
`define RRSE_STACK_DEPTH   8
`define RRSE_SP_W          3
`define RRSE_PC_W          13
`define RRSE_FADDR_W       7
// reset values
`define RRSE_W_RST         8'h00
`define RRSE_PC_RST        13'h0000
`define RRSE_SP_RST        3'h0
`define RRSE_WDT_RST       8'h00
`define RRSE_PRE_RST       8'h00
`endif

// >>> hw/rrse_exec.v
// What this block does
// - literal-exit places the 8-bit literal field into the working register
// - literal-exit opcode is 11 01xx followed by eight literal bits
// - literal-exit reloads pc from stack top and takes two cycles
// - subroutine-exit pops the stack into pc and takes two cycles
// - neither return instruction changes any status flag
// - rotate right through carry: old carry to bit 7, bit 0 to carry
// - rotate left through carry: old carry to bit 0, bit 7 to carry
// - destination bit 0 writes working register, 1 writes file register
// - rotates are one word, one cycle, changing only carry
// - power-down clears watchdog counter and its prescaler
// - power-down sets timeout flag and clears powerdown flag
// - power-down is single-cycle, then core halts its oscillator
`timescale 1ns/10ps
`default_nettype none
`include "rrse_defs.vh"
module rrse_exec (
  input  wire        core_clk_i,
  input  wire        arst_n_i,
  input  wire        instr_valid_i,
  input  wire [13:0] instr_i,
  input  wire [7:0]  file_rdata_i,
  input  wire        push_i,
  input  wire [12:0] push_addr_i,
  input  wire        wdt_tick_i,
  input  wire        wake_i,
  output wire [6:0]  file_addr_o,
  output reg  [7:0]  file_wdata_o,
  output reg         file_we_o,
  output reg  [7:0]  work_reg_o,
  output reg         carry_o,
  output reg         timeout_flag_o,
  output reg         powerdown_flag_o,
  output reg  [7:0]  watchdog_counter_o,
  output reg  [7:0]  wdt_prescaler_o,
  output reg  [12:0] pc_o,
  output reg         pc_load_o,
  output reg         flush_o,
  output wire        busy_o,
  output reg         osc_run_o,
  output reg  [12:0] stack_top_o
);
  reg  [12:0] stack_q [0:`RRSE_STACK_DEPTH-1];
  reg  [2:0]  sp_q;
  reg         ret_q;
  wire        is_lit_exit;
  wire        is_sub_exit;
  wire        is_rot_r;
  wire        is_rot_l;
  wire        is_pdown;
  wire        go;
  wire        dest_f;
  wire [2:0]  sp_prev;
  wire        is_ret;
  wire        is_rot;
  wire        do_push;
  wire [15:0] wdt_next;
  reg  [7:0]  rot_res;
  reg         rot_c;
  integer     i;

  assign go          = instr_valid_i & osc_run_o & ~ret_q;
  assign is_lit_exit = go & (instr_i[13:10] == `RRSE_LIT_EXIT_HI);
  assign is_sub_exit = go & (instr_i == `RRSE_SUB_EXIT_OP);
  assign is_rot_r    = go & (instr_i[13:8] == `RRSE_ROT_RIGHT_HI);
  assign is_rot_l    = go & (instr_i[13:8] == `RRSE_ROT_LEFT_HI);
  assign is_pdown    = go & (instr_i == `RRSE_POWERDOWN_OP);
  assign dest_f      = instr_i[`RRSE_DEST_BIT];
  assign file_addr_o = instr_i[6:0];
  assign sp_prev     = sp_q - 3'h1;
  assign busy_o      = ret_q;
  assign is_ret      = is_lit_exit | is_sub_exit;
  assign is_rot      = is_rot_r | is_rot_l;
  assign do_push     = push_i & go;
  assign wdt_next    = {watchdog_counter_o, wdt_prescaler_o} + 16'h0001;

  always @* begin
    if (is_rot_r) begin
      rot_res = {carry_o, file_rdata_i[7:1]};
      rot_c   = file_rdata_i[0];
    end else begin
      rot_res = {file_rdata_i[6:0], carry_o};
      rot_c   = file_rdata_i[7];
    end
  end

  // stack pointer: push moves up, pop moves back
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_q <= `RRSE_SP_RST;
    end else if (is_ret) begin
      sp_q <= sp_prev;
    end else if (do_push) begin
      sp_q <= sp_q + 3'h1;
    end
  end

  // return stack entries
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (i = 0; i < `RRSE_STACK_DEPTH; i = i + 1) begin
        stack_q[i] <= `RRSE_PC_RST;
      end
    end else if (do_push) begin
      stack_q[sp_q] <= push_addr_i;
    end
  end

  // visible top of stack
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stack_top_o <= `RRSE_PC_RST;
    end else if (is_ret) begin
      stack_top_o <= stack_q[sp_prev - 3'h1];
    end else if (do_push) begin
      stack_top_o <= push_addr_i;
    end
  end

  // second cycle of a return
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ret_q <= 1'b0;
    end else begin
      ret_q <= is_ret;
    end
  end

  // prefetched word is dropped in the cycle after the second return cycle
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flush_o <= 1'b0;
    end else begin
      flush_o <= ret_q;
    end
  end

  // restored program counter
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_o <= `RRSE_PC_RST;
    end else if (is_ret) begin
      pc_o <= stack_q[sp_prev];
    end
  end

  // program counter load strobe
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_load_o <= 1'b0;
    end else begin
      pc_load_o <= is_ret;
    end
  end

  // working register
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      work_reg_o <= `RRSE_W_RST;
    end else if (is_lit_exit) begin
      work_reg_o <= instr_i[7:0];
    end else if (is_rot && !dest_f) begin
      work_reg_o <= rot_res;
    end
  end

  // carry flag, touched by rotates only
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      carry_o <= 1'b0;
    end else if (is_rot) begin
      carry_o <= rot_c;
    end
  end

  // file register write data
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      file_wdata_o <= 8'h00;
    end else if (is_rot && dest_f) begin
      file_wdata_o <= rot_res;
    end
  end

  // file register write strobe
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      file_we_o <= 1'b0;
    end else begin
      file_we_o <= is_rot & dest_f;
    end
  end

  // timeout flag, returns leave it alone
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      timeout_flag_o <= 1'b1;
    end else if (is_pdown) begin
      timeout_flag_o <= 1'b1;
    end
  end

  // powerdown flag
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      powerdown_flag_o <= 1'b1;
    end else if (is_pdown) begin
      powerdown_flag_o <= 1'b0;
    end
  end

  // watchdog counter, clear wins over a tick
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      watchdog_counter_o <= `RRSE_WDT_RST;
    end else if (is_pdown) begin
      watchdog_counter_o <= `RRSE_WDT_RST;
    end else if (wdt_tick_i) begin
      watchdog_counter_o <= wdt_next[15:8];
    end
  end

  // watchdog prescaler, low byte of the chain
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt_prescaler_o <= `RRSE_PRE_RST;
    end else if (is_pdown) begin
      wdt_prescaler_o <= `RRSE_PRE_RST;
    end else if (wdt_tick_i) begin
      wdt_prescaler_o <= wdt_next[7:0];
    end
  end

  // oscillator run, power-down wins over wake
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_run_o <= 1'b1;
    end else if (is_pdown) begin
      osc_run_o <= 1'b0;
    end else if (wake_i) begin
      osc_run_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> test/rrse_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rrse_monitor(input wire logic core_clk_i,arst_n_i,instr_valid_i,
busy_o,osc_run_o,carry_o,file_we_o,pc_load_o,flush_o,timeout_flag_o,
powerdown_flag_o,input wire logic [13:0] instr_i,input wire logic [7:0]
file_rdata_i,work_reg_o,file_wdata_o,watchdog_counter_o,wdt_prescaler_o,
input wire logic [12:0] pc_o,stack_top_o);
  wire g=instr_valid_i&osc_run_o&~busy_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_lit; g&&instr_i[13:10]==4'hD|=>
    work_reg_o==8'($past(instr_i))&&pc_o==$past(stack_top_o); endproperty
  a_lit: assert property(p_lit) else $error("lit");
  property p_lsf; g&&instr_i[13:10]==4'hD|=>
    $stable(carry_o)&&$stable(timeout_flag_o); endproperty
  a_lsf: assert property(p_lsf) else $error("lsf");
  property p_ret; g&&instr_i==14'h0008|=>pc_load_o&&
    pc_o==$past(stack_top_o)&&$stable(carry_o); endproperty
  a_ret: assert property(p_ret) else $error("ret");
  property p_bsy; pc_load_o|->busy_o##1(flush_o&&!busy_o); endproperty
  a_bsy: assert property(p_bsy) else $error("bsy");
  property p_rrf; g&&instr_i[13:7]==7'h19|=>file_we_o&&carry_o==
    1'($past(file_rdata_i))&&file_wdata_o=={$past(carry_o),
    7'($past(file_rdata_i)>>1)}; endproperty
  a_rrf: assert property(p_rrf) else $error("rrf");
  property p_rlf; g&&instr_i[13:7]==7'h1A|=>!file_we_o&&
    work_reg_o=={7'($past(file_rdata_i)),$past(carry_o)}; endproperty
  a_rlf: assert property(p_rlf) else $error("rlf");
  property p_rotf; g&&instr_i[13:9]==5'h06|=>
    $stable(timeout_flag_o)&&$stable(powerdown_flag_o); endproperty
  a_rotf: assert property(p_rotf) else $error("rotf");
  property p_slp; g&&instr_i==14'h0063|=>watchdog_counter_o==0&&
    wdt_prescaler_o==0&&timeout_flag_o&&!powerdown_flag_o&&!osc_run_o;
  endproperty
  a_slp: assert property(p_slp) else $error("slp");
  cover property(pc_load_o);
  cover property(file_we_o);
  cover property(!osc_run_o);
endmodule
bind rrse_exec rrse_monitor u_mon(.*);
`default_nettype wire

// >>> test/rrse_exec_test.sv
`timescale 1ns/10ps
`default_nettype none
module rrse_exec_test;
  logic c=0,r=0,v=0,p=0,t=0,wk=0;
  logic [13:0] i=0;
  logic [7:0] fd=0;
  logic [12:0] pa=0;
  wire [7:0] wd,w,wc,wp;
  wire [12:0] pc,st;
  wire [6:0] fa;
  wire we,cy,to,pd,pl,fl,b,osc;
  int error_cnt=0,n_checks=0;
  always #20 c=~c;
  rrse_exec DUT(.core_clk_i(c),.arst_n_i(r),.instr_valid_i(v),.instr_i(i),
    .file_rdata_i(fd),.push_i(p),.push_addr_i(pa),.wdt_tick_i(t),
    .wake_i(wk),.file_addr_o(fa),.file_wdata_o(wd),.file_we_o(we),
    .work_reg_o(w),.carry_o(cy),.timeout_flag_o(to),.powerdown_flag_o(pd),
    .watchdog_counter_o(wc),.wdt_prescaler_o(wp),.pc_o(pc),.pc_load_o(pl),
    .flush_o(fl),.busy_o(b),.osc_run_o(osc),.stack_top_o(st));
  task chk(string n,logic [12:0] s,e);
    n_checks++;
    if(s!==e) begin
      error_cnt++;
      $display("Error %s exp %h got %h",n,e,s);
    end
  endtask
  task ex(logic [13:0] x);
    @(negedge c) v=1; i=x;
    @(negedge c) v=0;
  endtask
  task psh(logic [12:0] a);
    @(negedge c) p=1; pa=a; v=1; i=14'h0000;
    @(negedge c) p=0; v=0;
  endtask
  task t_ret;
    psh(13'h0123); psh(13'h0ABC);
    ex(14'h37A5);
    chk("w",w,8'hA5);
    chk("pc",pc,13'h0ABC);
    chk("busy",b,1);
    chk("pl",pl,1);
    chk("st",st,13'h0123);
    @(negedge c) chk("flush",fl,1);
    chk("pl0",pl,0);
    ex(14'h0008);
    chk("pc",pc,13'h0123);
    chk("to",to,1);
  endtask
  task t_rot;
    fd=8'hE6;
    ex(14'h0D05);
    chk("w",w,8'hCC);
    chk("c",cy,1);
    chk("we",we,0);
    chk("fa",fa,7'h05);
    ex(14'h0C85);
    chk("fw",wd,8'hF3);
    chk("c",cy,0);
    chk("we",we,1);
  endtask
  task t_slp;
    @(negedge c) t=1;
    @(negedge c) t=0;
    chk("wp",wp,1);
    ex(14'h0063);
    chk("wp",wp,0);
    chk("wc",wc,0);
    chk("to",to,1);
    chk("pd",pd,0);
    chk("osc",osc,0);
    ex(14'h37FF);
    chk("w",w,8'hCC);
    @(negedge c) wk=1;
    @(negedge c) wk=0;
    chk("osc",osc,1);
  endtask
  task report_and_stop;
    if(error_cnt==0&&n_checks>0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat(8) @(negedge c);
    r=1;
    t_ret; t_rot; t_slp;
    report_and_stop;
  end
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire
